//--- design/crc16_serial_ctrl.sv
// sequencer end of crc_link_if: frames bytes into serial bits
// assumes the user holds frame_len stable from start until done
`timescale 1ns/1ns
module crc16_serial_ctrl (
    input  wire logic  clk_sys,
    input  wire logic  arst_n,
    crc_link_if.ctrl   link,
    input  wire logic  start,
    input  wire logic  read_op,
    input  wire logic  [7:0] frame_len,
    input  wire logic  [7:0] byte_data,
    input  wire logic  byte_valid,
    output logic       byte_ready,
    output logic       busy,
    output logic       done,
    output logic       pass_ok,
    output logic       fail,
    output logic       err_flag,
    output logic       ser_out_n,
    output logic       step_clk
);
    import crc16_pkg::*;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    ctrl_state_t state_q;
    logic [1:0]  ph_q;
    logic [2:0]  bit_q;
    logic [7:0]  left_q;
    logic [7:0]  shreg_q;
    logic [1:0]  cnt_q;
    logic [1:0]  retry_q;
    logic        rd_q;
    logic        din_n_q;
    logic        shf_n_q;
    logic        strb_n_q;
    logic        init_n_q;
    logic        sel_q;
    logic        wclk_q;
    logic        ready_q;
    logic        busy_q;
    logic        done_q;
    logic        pass_q;
    logic        fail_q;
    logic        err_q;
    logic        load_pt;
    logic        stall;
    logic        byte_end;

    assign load_pt  = (state_q == ST_DATA) && (ph_q == PH_PRESENT)
                    && (bit_q == 3'h0);
    assign stall    = load_pt && !(ready_q && byte_valid);
    assign byte_end = (ph_q == PH_STROBE) && (bit_q == LAST_BIT);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q  <= ST_IDLE;
            ph_q     <= PH_PRESENT;
            bit_q    <= 3'h0;
            left_q   <= 8'h00;
            cnt_q    <= 2'h0;
            rd_q     <= 1'b0;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            pass_q   <= 1'b0;
            fail_q   <= 1'b0;
            init_n_q <= 1'b1;
        end else begin
            done_q <= 1'b0;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        rd_q     <= read_op;
                        busy_q   <= 1'b1;
                        cnt_q    <= 2'h0;
                        init_n_q <= 1'b0; // R4
                        state_q  <= ST_INIT;
                    end
                end
                ST_INIT: begin
                    if (cnt_q + 2'h1 >= INIT_CYC_W) begin
                        init_n_q <= 1'b1;
                        ph_q     <= PH_PRESENT;
                        bit_q    <= 3'h0;
                        left_q   <= PRE_BYTES;
                        state_q  <= ST_PRE;
                    end
                    cnt_q <= cnt_q + 2'h1;
                end
                ST_PRE, ST_DATA, ST_CHECK: begin
                    if (!stall) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == PH_STROBE) begin
                            bit_q <= bit_q + 3'h1;
                        end
                    end
                    if (byte_end) begin
                        left_q <= left_q - 8'h01;
                        if (left_q == ONE_BYTE) begin
                            case (state_q)
                                ST_PRE: begin
                                    left_q  <= frame_len;
                                    state_q <= ST_DATA;
                                end
                                ST_DATA: begin
                                    left_q  <= CHECK_BYTES;
                                    cnt_q   <= 2'h0;
                                    state_q <= rd_q ? ST_TAIL : ST_CHECK;
                                end
                                default: begin
                                    cnt_q   <= 2'h0;
                                    state_q <= ST_TAIL;
                                end
                            endcase
                        end
                    end
                end
                ST_TAIL: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == TAIL_CYC) begin
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= ST_IDLE;
                        if (rd_q) begin
                            pass_q <= link.check_pass; // R17
                            fail_q <= ~link.check_pass; // R17
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // retry counting on failed reads
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            retry_q <= 2'h0;
            err_q   <= 1'b0;
        end else if (pass_q) begin
            retry_q <= 2'h0;
            err_q   <= 1'b0;
        end else if (fail_q) begin
            if (retry_q + 2'h1 >= MAX_RETRY) begin
                err_q <= 1'b1; // R17
            end else begin
                retry_q <= retry_q + 2'h1; // R17
            end
        end
    end

    // ------------------------------------------------------------
    // serial pins: data, shift clock, byte strobe, select
    // ------------------------------------------------------------
    logic bits_on;

    assign bits_on = (state_q == ST_PRE) || (state_q == ST_DATA)
                   || (state_q == ST_CHECK);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            din_n_q  <= 1'b1;
            shf_n_q  <= 1'b1;
            strb_n_q <= 1'b1;
            shreg_q  <= 8'h00;
            ready_q  <= 1'b0;
        end else if (!bits_on) begin
            din_n_q  <= 1'b1;
            shf_n_q  <= 1'b1;
            strb_n_q <= 1'b1;
            ready_q  <= 1'b0;
        end else begin
            case (ph_q)
                PH_PRESENT: begin
                    shf_n_q  <= 1'b1;
                    strb_n_q <= 1'b1;
                    if (load_pt) begin
                        ready_q <= ~(ready_q & byte_valid);
                        if (ready_q && byte_valid) begin
                            din_n_q <= ~byte_data[7];
                            shreg_q <= {byte_data[6:0], 1'b0};
                            ready_q <= 1'b0;
                        end
                    end else if (state_q == ST_DATA) begin
                        din_n_q <= ~shreg_q[7];
                        shreg_q <= {shreg_q[6:0], 1'b0};
                    end else begin
                        din_n_q <= 1'b1; // R8
                    end
                end
                PH_SHIFT_FALL: begin
                    shf_n_q <= 1'b0;
                end
                PH_STROBE: begin
                    if (bit_q == LAST_BIT) begin
                        strb_n_q <= 1'b0;
                    end
                end
                default: begin
                    shf_n_q <= shf_n_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_q <= 1'b1;
        end else if (!bits_on) begin
            sel_q <= 1'b1; // R8 R11
        end else if (state_q == ST_DATA && !rd_q && left_q == ONE_BYTE
                     && ph_q == PH_SEL_DROP) begin
            sel_q <= 1'b0; // R10
        end
    end

    // free-running write clock for the divider
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wclk_q <= 1'b0;
        end else begin
            wclk_q <= ~wclk_q;
        end
    end

    // ------------------------------------------------------------
    // user-side copies
    // ------------------------------------------------------------
    logic ser_q;
    logic step_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ser_q  <= 1'b1;
            step_q <= 1'b0;
        end else begin
            ser_q  <= link.dout_n;
            step_q <= link.step_clk_div16;
        end
    end

    assign link.din_n             = din_n_q;
    assign link.bit_shift_clk_n   = shf_n_q;
    assign link.byte_strobe_n     = strb_n_q;
    assign link.init_n            = init_n_q;
    assign link.data_or_check_sel = sel_q;
    assign link.rd_mode           = rd_q;
    assign link.wclk              = wclk_q;
    assign byte_ready             = ready_q;
    assign busy                   = busy_q;
    assign done                   = done_q;
    assign pass_ok                = pass_q;
    assign fail                   = fail_q;
    assign err_flag               = err_q;
    assign ser_out_n              = ser_q;
    assign step_clk               = step_q;

endmodule : crc16_serial_ctrl

//--- design/crc16_serial_dev.sv
// serial crc16 generator/checker, device end of crc_link_if
// assumes link inputs are synchronous to clk_sys; edges found by compare
//
// Notes on behaviour
// R1: init low forces armed flag high
// R2: init low presets crc register to FFFF
// R3: first falling serial input clears armed flag
// R4: sequencer clears pass flags during initialisation
// R5: shift falls shift crc; rises update pass
// R6: byte strobe fall samples data/check select
// R7: write output: data unchanged, then check word
// R8: sequencer primes select high with leading zeros
// R9: check indicator low during check bits only
// R10: select lowered between last two byte strobes
// R11: select held low two byte times
// R12: after check word output stays high
// R13: write path idle in read mode
// R14: zero remainder after read sets pass
// R15: second pass output is exact complement
// R16: pass held until serial fall or init
// R17: sequencer counts failed reads, flags error on the third
// R18: write clock divided by sixteen, independent
// R19: poly x16+x12+x5+1, msb first, high byte
`timescale 1ns/1ns
module crc16_serial_dev (
    input  wire logic  clk_sys,
    input  wire logic  arst_n,
    crc_link_if.dev    link
);
    import crc16_pkg::*;

    // ------------------------------------------------------------
    // edge detection on link inputs
    // ------------------------------------------------------------
    logic din_prev_q;
    logic shf_prev_q;
    logic strb_prev_q;
    logic wclk_prev_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            din_prev_q  <= 1'b1;
            shf_prev_q  <= 1'b1;
            strb_prev_q <= 1'b1;
            wclk_prev_q <= 1'b0;
        end else begin
            din_prev_q  <= link.din_n;
            shf_prev_q  <= link.bit_shift_clk_n;
            strb_prev_q <= link.byte_strobe_n;
            wclk_prev_q <= link.wclk;
        end
    end

    logic din_fall;
    logic shf_fall;
    logic shf_rise;
    logic strb_fall;
    logic wclk_rise;

    assign din_fall  = din_prev_q & ~link.din_n;
    assign shf_fall  = shf_prev_q & ~link.bit_shift_clk_n;
    assign shf_rise  = ~shf_prev_q & link.bit_shift_clk_n;
    assign strb_fall = strb_prev_q & ~link.byte_strobe_n;
    assign wclk_rise = ~wclk_prev_q & link.wclk;

    // ------------------------------------------------------------
    // arming
    // ------------------------------------------------------------
    logic armed_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            armed_q <= 1'b1;
        end else if (!link.init_n) begin
            armed_q <= 1'b1; // R1
        end else if (din_fall) begin
            armed_q <= 1'b0; // R3
        end
    end

    // ------------------------------------------------------------
    // data/check select flip-flop
    // ------------------------------------------------------------
    logic sel_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_q <= 1'b1;
        end else if (strb_fall) begin
            sel_q <= link.data_or_check_sel; // R6
        end
    end

    // ------------------------------------------------------------
    // crc register
    // ------------------------------------------------------------
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic        b);
        logic fb;
        fb = c[15] ^ b;
        crc_step = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : CRC_ZERO);
    endfunction : crc_step

    logic        write_path;
    logic        check_phase;
    logic        chk_left;
    logic [15:0] crc_q;
    logic [4:0]  chk_cnt_q;

    // write path only; read mode leaves it dormant
    assign write_path  = ~link.rd_mode; // R13
    assign check_phase = write_path & ~sel_q & ~armed_q;
    assign chk_left    = (chk_cnt_q != CHK_BITS);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            crc_q <= CRC_PRESET;
        end else if (!link.init_n) begin
            crc_q <= CRC_PRESET; // R2
        end else if (shf_fall && !armed_q) begin
            if (check_phase) begin
                if (chk_left) begin
                    crc_q <= {crc_q[14:0], 1'b0}; // R5 R19
                end
            end else begin
                crc_q <= crc_step(crc_q, ~link.din_n); // R5 R19
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            chk_cnt_q <= 5'h00;
        end else if (!link.init_n || !check_phase) begin
            chk_cnt_q <= 5'h00;
        end else if (shf_fall && chk_left) begin
            chk_cnt_q <= chk_cnt_q + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // serial output and check word indicator
    // ------------------------------------------------------------
    logic dout_n_q;
    logic cw_n_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dout_n_q <= 1'b1;
        end else if (!write_path) begin
            dout_n_q <= 1'b1; // R13
        end else if (!check_phase) begin
            dout_n_q <= link.din_n; // R7
        end else if (shf_fall) begin
            // check bits go out true-sense, active low on the pin
            dout_n_q <= chk_left ? ~crc_q[15] : 1'b1; // R7 R12 R19
        end else if (shf_rise && !chk_left) begin
            // last check bit ends at the rise; line idles high after
            dout_n_q <= 1'b1; // R12
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cw_n_q <= 1'b1;
        end else if (!check_phase) begin
            cw_n_q <= 1'b1; // R9 R13
        end else if (shf_fall) begin
            cw_n_q <= ~chk_left; // R9
        end else if (shf_rise && !chk_left) begin
            cw_n_q <= 1'b1; // R9
        end
    end

    // ------------------------------------------------------------
    // read-mode pass flags
    // ------------------------------------------------------------
    logic pass_q;
    logic pass_n_q;
    logic pass_set;

    assign pass_set = shf_rise & link.rd_mode & ~armed_q
                    & (crc_q == CRC_ZERO);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pass_q   <= 1'b0;
            pass_n_q <= 1'b1;
        end else if (!link.init_n) begin
            pass_q   <= 1'b0; // R16
            pass_n_q <= 1'b1; // R15
        end else if (pass_set) begin
            // set wins over a coincident serial fall
            pass_q   <= 1'b1; // R5 R14
            pass_n_q <= 1'b0; // R15
        end else if (din_fall) begin
            pass_q   <= 1'b0; // R16
            pass_n_q <= 1'b1; // R15
        end
    end

    // ------------------------------------------------------------
    // timing clock divider
    // ------------------------------------------------------------
    logic [3:0] div_cnt_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_q <= 4'h0;
        end else if (wclk_rise) begin
            div_cnt_q <= div_cnt_q + DIV_INC; // R18
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.dout_n             = dout_n_q;
    assign link.armed_flag         = armed_q;
    assign link.check_pass         = pass_q;
    assign link.check_pass_n       = pass_n_q;
    assign link.checkword_active_n = cw_n_q;
    assign link.step_clk_div16     = div_cnt_q[DIV_MSB];

endmodule : crc16_serial_dev

//--- shared/crc16_pkg.sv
// constants shared by both ends of the serial crc16 link
// assumes one system clock at 10 MHz; all link pins move on that clock
package crc16_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          INIT_PULSE_NS = 90;
    localparam int          INIT_CYC      =
        (INIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  INIT_CYC_W    = 2'(INIT_CYC);

    // ------------------------------------------------------------
    // crc layout
    // ------------------------------------------------------------
    localparam int          CRC_W         = 16;
    localparam logic [15:0] CRC_PRESET    = 16'hFFFF;
    localparam logic [15:0] CRC_POLY      = 16'h1021;
    localparam logic [15:0] CRC_ZERO      = 16'h0000;
    localparam logic [4:0]  CHK_BITS      = 5'h10;
    localparam logic [7:0]  CHECK_BYTES   = 8'h02;
    localparam logic [3:0]  DIV_INC       = 4'h1;
    localparam int          DIV_MSB       = 3;

    // ------------------------------------------------------------
    // controller bit timing: four clocks per serial bit
    // ------------------------------------------------------------
    localparam logic [1:0]  PH_PRESENT    = 2'h0;
    localparam logic [1:0]  PH_SEL_DROP   = 2'h1;
    localparam logic [1:0]  PH_SHIFT_FALL = 2'h2;
    localparam logic [1:0]  PH_STROBE     = 2'h3;
    localparam logic [2:0]  LAST_BIT      = 3'h7;
    localparam logic [7:0]  PRE_BYTES     = 8'h02;
    localparam logic [7:0]  ONE_BYTE      = 8'h01;
    localparam logic [7:0]  TWO_BYTES     = 8'h02;
    localparam logic [1:0]  TAIL_CYC      = 2'h3;
    localparam logic [1:0]  MAX_RETRY     = 2'h3;

    // ------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_INIT  = 3'b001,
        ST_PRE   = 3'b010,
        ST_DATA  = 3'b011,
        ST_CHECK = 3'b100,
        ST_TAIL  = 3'b101
    } ctrl_state_t;

endpackage : crc16_pkg

//--- shared/crc_link_if.sv
// link between the crc16 generator/checker and its sequencer
// assumes both ends run on the same clk_sys; no clocking block
`timescale 1ns/1ns
interface crc_link_if;
    logic din_n;
    logic bit_shift_clk_n;
    logic byte_strobe_n;
    logic init_n;
    logic data_or_check_sel;
    logic rd_mode;
    logic wclk;
    logic dout_n;
    logic armed_flag;
    logic check_pass;
    logic check_pass_n;
    logic checkword_active_n;
    logic step_clk_div16;

    modport dev (
        input  din_n, bit_shift_clk_n, byte_strobe_n, init_n,
               data_or_check_sel, rd_mode, wclk,
        output dout_n, armed_flag, check_pass, check_pass_n,
               checkword_active_n, step_clk_div16
    );

    modport ctrl (
        output din_n, bit_shift_clk_n, byte_strobe_n, init_n,
               data_or_check_sel, rd_mode, wclk,
        input  dout_n, armed_flag, check_pass, check_pass_n,
               checkword_active_n, step_clk_div16
    );
endinterface : crc_link_if

//--- verif/crc_link_assertions.sv
// checker on the crc_link_if wires between the two ends
// assumes it sits beside the link in tb, one clk_sys domain
`timescale 1ns/1ns
module crc_link_assertions (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic din_n,
    input wire logic bit_shift_clk_n,
    input wire logic init_n,
    input wire logic rd_mode,
    input wire logic dout_n,
    input wire logic armed_flag,
    input wire logic check_pass,
    input wire logic check_pass_n,
    input wire logic checkword_active_n,
    input wire logic step_clk_div16
);
    logic [4:0] cwc_q;
    logic [7:0] gap_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // shift falls seen while check bits are out
    always_ff @(posedge clk_sys) begin
        if (!arst_n || checkword_active_n)
            cwc_q <= 5'h00;
        else if ($fell(bit_shift_clk_n))
            cwc_q <= cwc_q + 5'h01;
    end
    // cycles since the divided clock last moved
    always_ff @(posedge clk_sys) begin
        if (!arst_n || $changed(step_clk_div16))
            gap_q <= 8'h00;
        else
            gap_q <= gap_q + 8'h01;
    end
    init_arms_a: assert property (!init_n |=> armed_flag)
        else $error("armed flag not set by init");
    init_clears_a: assert property (!init_n |=> !check_pass)
        else $error("pass flag kept through init");
    din_disarms_a: assert property (armed_flag && init_n && $fell(din_n)
        |=> !armed_flag)
        else $error("armed flag kept after serial fall");
    pass_holds_a: assert property (check_pass && init_n && !$fell(din_n)
        |=> check_pass)
        else $error("pass flag dropped without cause");
    pass_compl_a: assert property (check_pass_n == !check_pass)
        else $error("pass outputs not complementary");
    read_quiet_a: assert property (rd_mode && $past(rd_mode)
        |-> dout_n && checkword_active_n)
        else $error("write path active in read mode");
    check_len_a: assert property (!checkword_active_n
        |-> cwc_q <= 5'h10 && !rd_mode)
        else $error("check word longer than sixteen bits");
    div_period_a: assert property ($fell(step_clk_div16)
        |-> gap_q == 8'h0F)
        else $error("divided clock half period wrong");
    cover property ($rose(check_pass));
    cover property ($fell(checkword_active_n));
    cover property ($rose(step_clk_div16));
endmodule : crc_link_assertions

//--- verif/tb.sv
// testbench: sequencer and generator/checker joined over crc_link_if
// assumes the package, link and both ends are compiled first
`timescale 1ns/1ns
module tb;
    import crc16_pkg::*;
    logic        clk_sys = 1'b0, arst_n = 1'b0, start = 1'b0;
    logic        read_op = 1'b0, byte_valid = 1'b1, pv, fv;
    logic [7:0]  frame_len = 8'h00, byte_data = 8'h00;
    logic        byte_ready, busy, done, pass_ok, fail, err_flag;
    logic        ser_out_n, step_clk;
    logic [1:0]  sh = 2'h3;
    logic [15:0] csr;
    logic [31:0] dsr;
    logic [7:0]  fb [8] = '{8'hA1, 8'h5C, 8'h3E, 8'h00, 8'h00, 8'h00,
                            8'h00, 8'h00};
    int          miscompares = 0, checked = 0, ncw = 0;
    crc_link_if link ();
    crc16_serial_dev crc16_serial_dev_i (.clk_sys, .arst_n, .link);
    crc16_serial_ctrl crc16_serial_ctrl_i (.clk_sys, .arst_n, .link,
        .start, .read_op, .frame_len, .byte_data, .byte_valid,
        .byte_ready, .busy, .done, .pass_ok, .fail, .err_flag,
        .ser_out_n, .step_clk);
    crc_link_assertions crc_link_assertions_i (.clk_sys, .arst_n,
        .din_n(link.din_n), .bit_shift_clk_n(link.bit_shift_clk_n),
        .init_n(link.init_n), .rd_mode(link.rd_mode),
        .dout_n(link.dout_n), .armed_flag(link.armed_flag),
        .check_pass(link.check_pass), .check_pass_n(link.check_pass_n),
        .checkword_active_n(link.checkword_active_n),
        .step_clk_div16(link.step_clk_div16));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] crc_of(input int n);
        logic [15:0] c;
        c = CRC_PRESET;
        for (int k = 0; k < n; k++)
            for (int b = 7; b >= 0; b--)
                c = {c[14:0], 1'b0}
                    ^ ((c[15] ^ fb[k][b]) ? CRC_POLY : CRC_ZERO);
        return c;
    endfunction : crc_of
    // bits on dout_n, two cycles after each shift fall
    always @(posedge clk_sys) begin
        sh <= {sh[0], link.bit_shift_clk_n};
        if (sh == 2'b10 && !link.bit_shift_clk_n) begin
            if (!link.checkword_active_n) begin
                csr <= {csr[14:0], ~link.dout_n};
                ncw <= ncw + 1;
            end
            else
                dsr <= {dsr[30:0], ~link.dout_n};
        end
    end
    task automatic frame(input logic rd, input int n);
        int i;
        bit seen;
        i = 0;
        seen = 1'b0;
        ncw = 0;
        start <= 1'b1;
        read_op <= rd;
        frame_len <= 8'(n);
        byte_data <= fb[0];
        @(posedge clk_sys);
        start <= 1'b0;
        repeat (3000) begin
            @(posedge clk_sys);
            if (byte_ready && i < n - 1) begin
                i++;
                byte_data <= fb[i];
            end
            if (done) begin
                pv = pass_ok;
                fv = fail;
                seen = 1'b1;
                break;
            end
        end
        if (!seen) begin
            miscompares++;
            $display("[ERR] %0t frame never finished", $time);
        end
        @(posedge clk_sys);
    endtask : frame
    task automatic t_write(input int n);
        logic [31:0] e;
        logic        s;
        e = '0;
        for (int k = 0; k < n; k++)
            e = {e[23:0], fb[k]};
        frame(1'b0, n);
        chk(dsr & ~(32'hFFFF_FFFF << (8 * n)), e);
        chk(csr, crc_of(n));
        chk(ncw, 16);
        chk(link.dout_n, 1'b1);
        chk(ser_out_n, 1'b1);
        s = link.step_clk_div16;
        @(posedge clk_sys);
        chk(step_clk, s);
        $display("write of %0d bytes finished", n);
    endtask : t_write
    task automatic t_read(input logic good);
        logic [15:0] c;
        c = crc_of(3);
        fb[3] = c[15:8];
        fb[4] = c[7:0] ^ {7'h00, !good};
        frame(1'b1, 5);
        chk(pv, good);
        chk(fv, !good);
        chk(link.check_pass, good);
        chk(link.check_pass_n, !good);
        chk(ncw, 0);
        chk(busy, 1'b0);
        $display("read with good=%0d finished", good);
    endtask : t_read
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        t_write(3);
        t_read(1'b1);
        t_read(1'b0);
        t_read(1'b0);
        chk(err_flag, 1'b0);
        t_read(1'b0);
        chk(err_flag, 1'b1);
        t_read(1'b1);
        chk(err_flag, 1'b0);
        t_write(1);
        tally_and_finish();
    end
endmodule : tb
